// file: tic_interval_counter.sv
// time-of-day cascade, interval counter and control registers on the sfr port
module tic_interval_counter
  import tic_pkg::*;
#(
  parameter int TICK_CYC = tic_pkg::TICK_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        tic_irq_en,
  input  wire logic        power_down,
  output logic      [7:0]  sfr_rdata,
  output logic             interval_irq,
  output logic             wake_req,
  output logic      [15:0] wake_vector
);
  import tic_pkg::*;

  localparam int TICK_W = (TICK_CYC > 2) ? $clog2(TICK_CYC) : 1;

  if (TICK_CYC < 2) begin : g_bad_tick
    $error("tic_interval_counter: TICK_CYC must be at least 2");
  end

  logic [7:0]  interval_timer_control_reg;
  logic [7:0]  interval_timer_control_next;
  logic [7:0]  interval_compare_value_reg;
  logic [7:0]  interval_compare_value_next;
  logic [7:0]  long_interval_timer_reg;
  logic [7:0]  long_interval_timer_next;
  logic [7:0]  sfr_rdata_reg;
  logic [7:0]  sfr_rdata_next;
  logic        irq_reg;
  logic        irq_next;
  logic        wake_reg;
  logic        wake_next;
  logic [15:0] vector_reg;
  logic [15:0] vector_next;

  logic              time_clock_enable;
  logic              interval_count_enable;
  logic              interval_match_flag;
  logic              single_interval_mode;
  tic_tbsel_t        tbsel;
  logic              wr_ctrl;
  logic              wr_cmp;
  logic              time_clear;
  logic [TICK_W-1:0] tick_cnt;
  logic              tick;
  logic [6:0]        fraction_second_count;
  logic [5:0]        sec_count;
  logic [5:0]        min_count;
  logic [4:0]        hour_count;
  logic              frac_wrap;
  logic              sec_wrap;
  logic              min_wrap;
  logic              hour_wrap;
  logic              sel_ovf;
  logic              advance;
  logic [7:0]        inc_val;
  logic              timeout;

  assign time_clock_enable     = interval_timer_control_reg[TIME_CLOCK_ENABLE_BIT];
  assign interval_count_enable = interval_timer_control_reg[IEN_BIT];
  assign interval_match_flag   = interval_timer_control_reg[FLAG_BIT];
  assign single_interval_mode  = interval_timer_control_reg[SINGLE_BIT];
  assign tbsel     = tic_tbsel_t'(interval_timer_control_reg[TBSEL_HI:TBSEL_LO]);
  assign wr_ctrl   = sfr_wr && (sfr_addr == ADDR_CTRL);
  assign wr_cmp    = sfr_wr && (sfr_addr == ADDR_CMP);
  assign time_clear = wr_ctrl && time_clock_enable && !sfr_wdata[TIME_CLOCK_ENABLE_BIT];

  tic_modcnt #(.WIDTH(TICK_W), .MAXV(TICK_CYC - 1)) u_tick (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .clr      (!time_clock_enable),
    .inc      (time_clock_enable),
    .load     (1'b0),
    .load_val ({TICK_W{1'b0}}),
    .count    (tick_cnt),
    .wrap     (tick)
  );

  tic_modcnt #(.WIDTH(7), .MAXV(FRAC_MAX)) u_frac (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .clr      (time_clear),
    .inc      (tick),
    .load     (sfr_wr && sfr_addr == ADDR_FRAC && !time_clock_enable),
    .load_val (sfr_wdata[6:0]),
    .count    (fraction_second_count),
    .wrap     (frac_wrap)
  );

  tic_modcnt #(.WIDTH(6), .MAXV(SEC_MAX)) u_sec (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .clr      (time_clear),
    .inc      (frac_wrap),
    .load     (sfr_wr && sfr_addr == ADDR_SEC && !time_clock_enable),
    .load_val (sfr_wdata[5:0]),
    .count    (sec_count),
    .wrap     (sec_wrap)
  );

  tic_modcnt #(.WIDTH(6), .MAXV(MIN_MAX)) u_min (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .clr      (time_clear),
    .inc      (sec_wrap),
    .load     (sfr_wr && sfr_addr == ADDR_MIN && !time_clock_enable),
    .load_val (sfr_wdata[5:0]),
    .count    (min_count),
    .wrap     (min_wrap)
  );

  tic_modcnt #(.WIDTH(5), .MAXV(HOUR_MAX)) u_hour (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .clr      (time_clear),
    .inc      (min_wrap),
    .load     (sfr_wr && sfr_addr == ADDR_HOUR && !time_clock_enable),
    .load_val (sfr_wdata[4:0]),
    .count    (hour_count),
    .wrap     (hour_wrap)
  );

  always_comb begin
    case (tbsel)
      TIC_TB_FRAC: sel_ovf = tick;
      TIC_TB_SEC:  sel_ovf = frac_wrap;
      TIC_TB_MIN:  sel_ovf = sec_wrap;
      TIC_TB_HOUR: sel_ovf = min_wrap;
      default:     sel_ovf = 1'b0;
    endcase
  end

  assign advance = interval_count_enable && time_clock_enable && sel_ovf;
  assign inc_val = 8'(long_interval_timer_reg + 1'b1);
  assign timeout = advance && (inc_val == interval_compare_value_reg);

  always_comb begin
    long_interval_timer_next    = long_interval_timer_reg;
    interval_compare_value_next = interval_compare_value_reg;
    interval_timer_control_next = interval_timer_control_reg;
    if (wr_cmp) begin
      interval_compare_value_next = sfr_wdata;
    end
    if (!interval_count_enable || timeout) begin
      long_interval_timer_next = RESET_VALUE;
    end else if (advance) begin
      long_interval_timer_next = inc_val;
    end
    if (wr_ctrl) begin
      interval_timer_control_next = sfr_wdata & CTRL_WMASK;
    end
    if (timeout) begin
      interval_timer_control_next[FLAG_BIT] = 1'b1;
      if (single_interval_mode) begin
        interval_timer_control_next[IEN_BIT] = 1'b0;
      end
    end
  end

  always_comb begin
    irq_next    = interval_match_flag && tic_irq_en;
    wake_next   = interval_match_flag && tic_irq_en && power_down;
    vector_next = wake_next ? WAKE_VECTOR : 16'h0000;
  end

  always_comb begin
    sfr_rdata_next = sfr_rdata_reg;
    if (sfr_rd) begin
      case (sfr_addr)
        ADDR_CTRL: sfr_rdata_next = interval_timer_control_reg;
        ADDR_FRAC: sfr_rdata_next = {1'b0, fraction_second_count};
        ADDR_SEC:  sfr_rdata_next = {2'b00, sec_count};
        ADDR_MIN:  sfr_rdata_next = {2'b00, min_count};
        ADDR_HOUR: sfr_rdata_next = {3'b000, hour_count};
        ADDR_CMP:  sfr_rdata_next = interval_compare_value_reg;
        default:   sfr_rdata_next = RESET_VALUE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      interval_timer_control_reg <= RESET_VALUE;
      interval_compare_value_reg <= RESET_VALUE;
      long_interval_timer_reg    <= RESET_VALUE;
      sfr_rdata_reg              <= RESET_VALUE;
      irq_reg                    <= 1'b0;
      wake_reg                   <= 1'b0;
      vector_reg                 <= 16'h0000;
    end else begin
      interval_timer_control_reg <= interval_timer_control_next;
      interval_compare_value_reg <= interval_compare_value_next;
      long_interval_timer_reg    <= long_interval_timer_next;
      sfr_rdata_reg              <= sfr_rdata_next;
      irq_reg                    <= irq_next;
      wake_reg                   <= wake_next;
      vector_reg                 <= vector_next;
    end
  end

  assign sfr_rdata    = sfr_rdata_reg;
  assign interval_irq = irq_reg;
  assign wake_req     = wake_reg;
  assign wake_vector  = vector_reg;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence timeout_seq;
    advance && (inc_val == interval_compare_value_reg);
  endsequence

  sequence flag_up_seq;
    interval_match_flag && tic_irq_en;
  endsequence

  flag_set_a: assert property (timeout_seq |=> interval_match_flag)
    else $error("match did not set flag");
  irq_path_a: assert property (flag_up_seq ##1 flag_up_seq |=> interval_irq)
    else $error("interrupt not raised");
  wake_vec_a: assert property ((flag_up_seq and power_down) |=> (wake_req && wake_vector == WAKE_VECTOR))
    else $error("wake or vector wrong");
  single_shot_a: assert property ((timeout_seq and single_interval_mode) |=> !interval_count_enable)
    else $error("single interval kept enable");
  reload_zero_a: assert property (timeout_seq |=> long_interval_timer_reg == 8'h00)
    else $error("counter not reloaded");
  advance_sel_a: assert property (advance && !timeout |=> long_interval_timer_reg == $past(long_interval_timer_reg) + 8'h01)
    else $error("interval counter missed overflow");
  sec_base_a: assert property (tbsel == TIC_TB_SEC && interval_count_enable && time_clock_enable && !frac_wrap |-> !advance)
    else $error("advance without seconds overflow");
  time_clear_a: assert property (time_clear |=> (fraction_second_count == 7'd0 && sec_count == 6'd0 && min_count == 6'd0 && hour_count == 5'd0))
    else $error("time registers not cleared");
  stopped_a: assert property (!time_clock_enable && !sfr_wr |=> $stable(fraction_second_count) && $stable(sec_count))
    else $error("time moved while stopped");
  frac_roll_a: assert property (tick && fraction_second_count == 7'd127 && !sfr_wr |=> fraction_second_count == 7'd0 && sec_count != $past(sec_count))
    else $error("fraction rollover lost");
  hour_wrap_a: assert property (min_wrap && hour_count == 5'd23 |=> hour_count == 5'd0)
    else $error("hours did not wrap");
endmodule

// file: tic_modcnt.sv
// modulo counter with clear, load and carry-out used for every time stage
module tic_modcnt #(
  parameter int WIDTH = 8,
  parameter int MAXV  = 59
) (
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic             clr,
  input  wire logic             inc,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  output logic      [WIDTH-1:0] count,
  output logic                  wrap
);
  localparam logic [WIDTH-1:0] MAX_W  = WIDTH'(MAXV);
  localparam logic [WIDTH-1:0] ZERO_W = '0;

  if (WIDTH < 1 || MAXV < 1 || MAXV >= (1 << WIDTH)) begin : g_bad
    $error("tic_modcnt: MAXV does not fit WIDTH");
  end

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  // out-of-range preloads roll over at the next step
  assign wrap  = inc && !clr && !load && (count_reg >= MAX_W);
  assign count = count_reg;

  always_comb begin
    count_next = count_reg;
    if (clr) begin
      count_next = ZERO_W;
    end else if (load) begin
      count_next = load_val;
    end else if (inc) begin
      count_next = wrap ? ZERO_W : WIDTH'(count_reg + 1'b1);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= ZERO_W;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule

// file: tic_pkg.sv
// package of addresses, fields and timing for the crystal time interval counter
// What this block does
// - timeouts span 1/128 second to 256 hours (compare 00h) via timebase and compare value
// - counter logic runs on clk_sys, with a 1/128 s tick every TICK_CYCLES clk_sys cycles
// - six software registers; the control register holds timebase, enables, match flag
// - interval counter advances on each increment of the selected time register
// - counter equal to compare sets match flag bit 2 and interrupt if enabled
// - in power-down with interrupt enabled, match flag wakes core to vector 0053h
// - software may preload the time registers to run as real-time clock
// - control register at address A1h, resets to 00h, not bit addressable
// - timebase field: 00 1/128 s, 01 seconds, 10 minutes, 11 hours
// - single-interval mode clears count enable on timeout; otherwise counter reloads
// - clearing time clock enable stops and clears time registers; writable while low
// - fraction register counts 0 to 127 each 1/128 s, rollover bumps seconds
package tic_pkg;
  localparam logic [7:0]  ADDR_CTRL    = 8'ha1;
  localparam logic [7:0]  ADDR_FRAC    = 8'ha2;
  localparam logic [7:0]  ADDR_SEC     = 8'ha3;
  localparam logic [7:0]  ADDR_MIN     = 8'ha4;
  localparam logic [7:0]  ADDR_HOUR    = 8'ha5;
  localparam logic [7:0]  ADDR_CMP     = 8'ha6;
  localparam logic [7:0]  RESET_VALUE  = 8'h00;
  localparam logic [7:0]  CTRL_WMASK   = 8'h3f;
  localparam int          TIME_CLOCK_ENABLE_BIT     = 0;
  localparam int          IEN_BIT      = 1;
  localparam int          FLAG_BIT     = 2;
  localparam int          SINGLE_BIT   = 3;
  localparam int          TBSEL_LO     = 4;
  localparam int          TBSEL_HI     = 5;
  localparam logic [15:0] WAKE_VECTOR  = 16'h0053;
  localparam int          FRAC_MAX     = 127;
  localparam int          SEC_MAX      = 59;
  localparam int          MIN_MAX      = 59;
  localparam int          HOUR_MAX     = 23;
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          TICK_PERIOD_NS = 7812500;
  localparam int          TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    TIC_TB_FRAC = 2'b00,
    TIC_TB_SEC  = 2'b01,
    TIC_TB_MIN  = 2'b10,
    TIC_TB_HOUR = 2'b11
  } tic_tbsel_t;
endpackage

// file: tic_testbench.sv
// self-checking bench for the crystal time interval counter
module testbench
  import tic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 4;
  logic        clk_sys;
  logic        arst_n;
  logic [7:0]  sfr_addr;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_wdata;
  logic        tic_irq_en;
  logic        power_down;
  logic [7:0]  sfr_rdata;
  logic        interval_irq;
  logic        wake_req;
  logic [15:0] wake_vector;
  logic [7:0]  rv;
  int          miscompares;
  int          cmp_count;
  int          n;

  tic_interval_counter #(.TICK_CYC(TK)) DUT (
    .clk_sys      (clk_sys),
    .arst_n       (arst_n),
    .sfr_addr     (sfr_addr),
    .sfr_wr       (sfr_wr),
    .sfr_rd       (sfr_rd),
    .sfr_wdata    (sfr_wdata),
    .tic_irq_en   (tic_irq_en),
    .power_down   (power_down),
    .sfr_rdata    (sfr_rdata),
    .interval_irq (interval_irq),
    .wake_req     (wake_req),
    .wake_vector  (wake_vector)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic close_out();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_wr    <= 1'b1;
    sfr_addr  <= a;
    sfr_wdata <= d;
    @(posedge clk_sys);
    sfr_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    sfr_rd   <= 1'b1;
    sfr_addr <= a;
    @(posedge clk_sys);
    sfr_rd   <= 1'b0;
    #1;
    d = sfr_rdata;
  endtask

  // bounded wait for the interrupt line, cycles counted in cnt
  task automatic wait_irq(input int lim, output int cnt);
    cnt = 0;
    #1;
    while (interval_irq !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      cnt++;
      if (cnt > lim) begin
        miscompares++;
        $display("unexpected interval_irq expected 1 seen %b", interval_irq);
        close_out();
      end
    end
  endtask

  initial begin
    arst_n     = 1'b0;
    sfr_addr   = 8'h00;
    sfr_wr     = 1'b0;
    sfr_rd     = 1'b0;
    sfr_wdata  = 8'h00;
    tic_irq_en = 1'b1;
    power_down = 1'b0;
    miscompares = 0;
    cmp_count   = 0;
    cyc(2);
    arst_n <= 1'b1;
    // reset values of all registers and an unmapped place
    for (int a = 8'ha1; a <= 8'ha7; a++) begin
      rd(a[7:0], rv);
      check("reset reg", 8'h00, rv);
    end
    check("irq after reset", 1'b0, interval_irq);
    wr(ADDR_CTRL, 8'hff);
    rd(ADDR_CTRL, rv);
    check("ctrl bits", 8'h3f, rv);
    wr(ADDR_SEC, 8'h05);
    rd(ADDR_SEC, rv);
    check("sec write while running", 8'h00, rv);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_FRAC, rv);
    check("frac after stop", 8'h00, rv);
    // preload the last moment of the day and let it roll over
    wr(ADDR_FRAC, 8'h7f);
    wr(ADDR_SEC, 8'h3b);
    wr(ADDR_MIN, 8'h3b);
    wr(ADDR_HOUR, 8'h17);
    rd(ADDR_HOUR, rv);
    check("hour preload", 8'h17, rv);
    wr(ADDR_CTRL, 8'h01);
    n = 0;
    rv = 8'h7f;
    while (rv === 8'h7f && n < 20) begin
      rd(ADDR_FRAC, rv);
      n++;
    end
    check("frac wrap", 8'h00, rv);
    rd(ADDR_SEC, rv);
    check("sec wrap", 8'h00, rv);
    rd(ADDR_MIN, rv);
    check("min wrap", 8'h00, rv);
    rd(ADDR_HOUR, rv);
    check("hour wrap", 8'h00, rv);
    wr(ADDR_CTRL, 8'h00);
    // each timebase, single interval; lower stage overflows first where it can
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_FRAC, (s == 1) ? 8'h7e : 8'h7f);
      wr(ADDR_SEC, (s == 2) ? 8'h3a : 8'h3b);
      wr(ADDR_MIN, 8'h3b);
      wr(ADDR_CMP, 8'h01);
      wr(ADDR_CTRL, {2'b00, s[1:0], 4'b1011});
      wait_irq(130 * TK, n);
      check("timebase cycles", 16'(((s == 2) ? 129 : (s == 1) ? 2 : 1) * TK + 1), 16'(n));
      rd(ADDR_CTRL, rv);
      check("ctrl after single", {2'b00, s[1:0], 4'b1101}, rv);
      wr(ADDR_CTRL, 8'h00);
    end
    // repeat mode, three fraction ticks per interval, wake in power-down
    power_down <= 1'b1;
    wr(ADDR_CMP, 8'h03);
    wr(ADDR_CTRL, 8'h03);
    wait_irq(3 * TK + 6, n);
    check("match cycles", 16'(3 * TK + 1), 16'(n));
    check("wake_req", 1'b1, wake_req);
    check("wake_vector", 16'h0053, wake_vector);
    wr(ADDR_CTRL, 8'h03);
    cyc(2);
    check("irq after clear", 1'b0, interval_irq);
    wait_irq(3 * TK + 6, n);
    rd(ADDR_CTRL, rv);
    check("ctrl repeat", 8'h07, rv);
    @(posedge clk_sys);
    power_down <= 1'b0;
    cyc(3);
    check("wake_req off", 1'b0, wake_req);
    check("wake_vector off", 16'h0000, wake_vector);
    @(posedge clk_sys);
    tic_irq_en <= 1'b0;
    cyc(3);
    check("irq masked", 1'b0, interval_irq);
    close_out();
  end
endmodule
